// file: design/tei_pkg.sv
/*
  Package for the throttle event interrupt block: register offsets, field
  positions, reset values and the register access carrier.
  Assumes a simple internal register port with one-cycle read and write strobes.
*/
package tei_pkg;
  localparam int unsigned TEI_ADDR_W = 8;
  localparam int unsigned TEI_DATA_W = 32;
  localparam int unsigned TEI_NFLAG = 5;
  localparam logic [TEI_ADDR_W-1:0] TEI_STATUS_OFS = 8'h1c;
  localparam logic [TEI_ADDR_W-1:0] TEI_ENABLE_OFS = 8'h20;
  localparam int unsigned TEI_BIT_HI_FALL = 0;
  localparam int unsigned TEI_BIT_LO_FALL = 1;
  localparam int unsigned TEI_BIT_HI_RISE = 2;
  localparam int unsigned TEI_BIT_LO_RISE = 3;
  localparam int unsigned TEI_BIT_FORCE = 4;
  localparam logic [TEI_NFLAG-1:0] TEI_STATUS_RST = 5'h10;
  localparam logic [TEI_NFLAG-1:0] TEI_ENABLE_RST = 5'h00;
  localparam logic [TEI_DATA_W-1:0] TEI_RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [TEI_ADDR_W-1:0] addr;
    logic [TEI_DATA_W-1:0] wdata;
  } tei_reg_req_t;
endpackage

// file: design/tei_throttle_event_interrupt.sv
/*
  Throttle event interrupt: five sticky event flags, five enables, one
  interrupt toward the embedded processor. Status and enable sit behind a
  plain register port with separate read and write strobes.
  Assumes all inputs synchronous to ref_clk and one register request per cycle;
  the timer outputs idle low, so their history resets low.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// - The forced-throttle flag, status bit 4, is set while the active-low forced-throttle input is low.
// - Status bit 3 is set when the low-side timer output rises from zero to one.
// - Status bit 2 is set when the high-side timer output rises from zero to one.
// - Status bit 1 is set when the low-side timer output falls from one to zero.
// - Status bit 0 is set when the high-side timer output falls from one to zero.
// - Writing a one to a status bit clears that flag.
// - Writing a zero to a status bit leaves that flag as it is.
// - The interrupt is raised when enable bit 4 and the forced-throttle flag are both one.
// - With its enable at zero the forced-throttle flag raises no interrupt yet still records.
// - The four edge flags watch the low-side and high-side comparator timer outputs.
module tei_throttle_event_interrupt
  import tei_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // event sources
  input wire logic force_throttle_b,
  input wire logic low_side_timer_out,
  input wire logic high_side_timer_out,
  // register port
  input wire tei_pkg::tei_reg_req_t reg_req,
  output logic [tei_pkg::TEI_DATA_W-1:0] reg_rdata,
  // interrupt
  output logic throttle_irq
);
  import tei_pkg::*;

  // timer channels watched for edges
  localparam int unsigned TEI_CHAN_LO = 0;
  localparam int unsigned TEI_CHAN_HI = 1;
  localparam int unsigned TEI_NCHAN = 2;

  // reset levels of the timer history and the interrupt line
  localparam logic TEI_PREV_RST = 1'b0;
  localparam logic TEI_IRQ_RST = 1'b0;

  // register picked by the port address
  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_STATUS,
    SEL_ENABLE,
    SEL_OTHER
  } tei_sel_t;

  // register decode
  tei_sel_t wr_sel;
  tei_sel_t rd_sel;
  logic status_wr;
  logic enable_wr;

  // timer edge detection
  logic [TEI_NCHAN-1:0] timer_now;
  logic [TEI_NCHAN-1:0] timer_prev_q;
  logic [TEI_NCHAN-1:0] timer_rise;
  logic [TEI_NCHAN-1:0] timer_fall;

  // sticky flags and their update terms
  logic [TEI_NFLAG-1:0] event_set;
  logic [TEI_NFLAG-1:0] clr_mask;
  logic [TEI_NFLAG-1:0] status_d;
  logic [TEI_NFLAG-1:0] status_q;

  // enables
  logic [TEI_NFLAG-1:0] enable_d;
  logic [TEI_NFLAG-1:0] enable_q;

  // interrupt terms
  logic [TEI_NFLAG-1:0] masked;
  logic irq_d;
  logic irq_q;

  // read path
  logic [TEI_DATA_W-1:0] rdata_d;
  logic [TEI_DATA_W-1:0] rdata_q;

  // address decode, shared by the write and read paths
  function automatic tei_sel_t reg_sel(input logic [TEI_ADDR_W-1:0] addr);
    case (addr)
      TEI_STATUS_OFS: begin
        reg_sel = SEL_STATUS;
      end
      TEI_ENABLE_OFS: begin
        reg_sel = SEL_ENABLE;
      end
      default: begin
        reg_sel = SEL_OTHER;
      end
    endcase
  endfunction

  // flag bits of a written word; reserved upper bits are dropped
  function automatic logic [TEI_NFLAG-1:0] flag_field(input logic [TEI_DATA_W-1:0] word);
    flag_field = word[TEI_NFLAG-1:0];
  endfunction

  // flags placed in a read word, reserved bits read zero
  function automatic logic [TEI_DATA_W-1:0] read_word(input logic [TEI_NFLAG-1:0] flags);
    read_word = TEI_RD_ZERO;
    read_word[TEI_NFLAG-1:0] = flags;
  endfunction

  // event that sets the flag at one status position
  function automatic logic flag_event(input int unsigned pos, input logic force_b,
    input logic [TEI_NCHAN-1:0] rise, input logic [TEI_NCHAN-1:0] fall);
    case (pos)
      TEI_BIT_FORCE: begin
        flag_event = ~force_b;
      end
      TEI_BIT_LO_RISE: begin
        flag_event = rise[TEI_CHAN_LO];
      end
      TEI_BIT_HI_RISE: begin
        flag_event = rise[TEI_CHAN_HI];
      end
      TEI_BIT_LO_FALL: begin
        flag_event = fall[TEI_CHAN_LO];
      end
      TEI_BIT_HI_FALL: begin
        flag_event = fall[TEI_CHAN_HI];
      end
      default: begin
        flag_event = 1'b0;
      end
    endcase
  endfunction

  // next value of one flag; the set term comes last so it wins over a clear
  function automatic logic next_flag(input logic q, input logic clr, input logic set);
    next_flag = q & ~clr;
    next_flag = next_flag | set;
  endfunction

  // a register counts as selected only while its request bit is high
  always_comb begin
    wr_sel = SEL_IDLE;
    rd_sel = SEL_IDLE;
    if (reg_req.wr_en) begin
      wr_sel = reg_sel(reg_req.addr);
    end
    if (reg_req.rd_en) begin
      rd_sel = reg_sel(reg_req.addr);
    end
  end

  // write strobes per register; unmapped writes are dropped
  always_comb begin
    status_wr = 1'b0;
    enable_wr = 1'b0;
    case (wr_sel)
      SEL_STATUS: begin
        status_wr = 1'b1;
      end
      SEL_ENABLE: begin
        enable_wr = 1'b1;
      end
      default: begin
        status_wr = 1'b0;
      end
    endcase
  end

  assign timer_now[TEI_CHAN_LO] = low_side_timer_out;
  assign timer_now[TEI_CHAN_HI] = high_side_timer_out;

  // history resets low like an idle timer, so release makes no false edge
  for (genvar c = 0; c < TEI_NCHAN; c++) begin : g_chan
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        timer_prev_q[c] <= TEI_PREV_RST;
      end else begin
        timer_prev_q[c] <= timer_now[c];
      end
    end

    always_comb begin
      timer_rise[c] = timer_now[c] & ~timer_prev_q[c];
    end

    always_comb begin
      timer_fall[c] = ~timer_now[c] & timer_prev_q[c];
    end
  end

  // write one to clear, zero leaves the flag
  always_comb begin
    clr_mask = '0;
    if (status_wr) begin
      clr_mask = flag_field(reg_req.wdata);
    end
  end

  // one sticky flag per position; an event in the clearing cycle is never lost
  for (genvar f = 0; f < TEI_NFLAG; f++) begin : g_flag
    always_comb begin
      event_set[f] = flag_event(f, force_throttle_b, timer_rise, timer_fall);
    end

    always_comb begin
      status_d[f] = next_flag(status_q[f], clr_mask[f], event_set[f]);
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        // forced flag set, edge flags clear
        status_q[f] <= TEI_STATUS_RST[f];
      end else begin
        status_q[f] <= status_d[f];
      end
    end

    // flag gated by its own enable
    always_comb begin
      masked[f] = status_d[f] & enable_d[f];
    end
  end

  // enable register, one bit per flag position
  for (genvar e = 0; e < TEI_NFLAG; e++) begin : g_enable
    always_comb begin
      enable_d[e] = enable_q[e];
      if (enable_wr) begin
        enable_d[e] = reg_req.wdata[e];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        enable_q[e] <= TEI_ENABLE_RST[e];
      end else begin
        enable_q[e] <= enable_d[e];
      end
    end
  end

  // read mux; a read in a write cycle sees the values before the write
  always_comb begin
    case (rd_sel)
      SEL_STATUS: begin
        rdata_d = read_word(status_q);
      end
      SEL_ENABLE: begin
        rdata_d = read_word(enable_q);
      end
      SEL_OTHER: begin
        rdata_d = TEI_RD_ZERO;
      end
      default: begin
        rdata_d = rdata_q;
      end
    endcase
  end

  // read data holds until the next read, since the port has no valid strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_q <= TEI_RD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // any enabled flag; next-state terms so a fresh enable acts at once
  always_comb begin
    irq_d = 1'b0;
    for (int unsigned i = 0; i < TEI_NFLAG; i++) begin
      irq_d = irq_d | masked[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_q <= TEI_IRQ_RST;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign throttle_irq = irq_q;
endmodule
`default_nettype wire

// file: test/tei_asserts.sv
/* checker for the throttle event interrupt ports.
   assumes reg_req changes only just after the rising ref_clk edge. */
`timescale 1ns/1ns
`default_nettype none
module tei_asserts
  import tei_pkg::*;
(
  // clock, reset, inputs
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic force_throttle_b,
  input wire logic low_side_timer_out,
  input wire logic high_side_timer_out,
  input wire tei_pkg::tei_reg_req_t reg_req,
  // outputs
  input wire logic [tei_pkg::TEI_DATA_W-1:0] reg_rdata,
  input wire logic throttle_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // enable shadow; a write in the same cycle is left out, its timing is open
  logic [4:0] en_q;
  wire logic ew = reg_req.wr_en && reg_req.addr == TEI_ENABLE_OFS;
  always_ff @(posedge ref_clk) if (!rst_b) en_q <= TEI_ENABLE_RST; else if (ew) en_q <= reg_req.wdata[4:0];
  rd_hold_a: assert property (!reg_req.rd_en |=> $stable(reg_rdata)) else $error("read data moved");
  force_irq_a: assert property (!force_throttle_b && en_q[4] && !ew
    |=> throttle_irq) else $error("no force irq");
  mask_irq_a: assert property (en_q == 5'h00 && !ew |=> !throttle_irq) else $error("masked irq");
  lo_rise_a: assert property ($rose(low_side_timer_out) && en_q[3] && !ew
    |=> throttle_irq) else $error("no low rise irq");
  hi_rise_a: assert property ($rose(high_side_timer_out) && en_q[2] && !ew
    |=> throttle_irq) else $error("no high rise irq");
  lo_fall_a: assert property ($fell(low_side_timer_out) && $past(rst_b) && en_q[1] && !ew
    |=> throttle_irq) else $error("no low fall irq");
  hi_fall_a: assert property ($fell(high_side_timer_out) && $past(rst_b) && en_q[0] && !ew
    |=> throttle_irq) else $error("no high fall irq");
  en_read_a: assert property (reg_req.rd_en && reg_req.addr == TEI_ENABLE_OFS
    |=> reg_rdata == {27'h0, $past(en_q)}) else $error("enable read");
endmodule
bind tei_throttle_event_interrupt tei_asserts u_tei_asserts(.ref_clk, .rst_b, .force_throttle_b, .low_side_timer_out,
  .high_side_timer_out, .reg_req, .reg_rdata, .throttle_irq);
`default_nettype wire

// file: test/throttle_event_interrupt_test.sv
/* bench for the throttle event interrupt.
   assumes the design package is compiled first. */
`timescale 1ns/1ns
`default_nettype none
module throttle_event_interrupt_test;
  import tei_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, force_throttle_b = 1'b1, lo = 1'b0, hi = 1'b0, throttle_irq;
  tei_reg_req_t req = '0;
  logic [31:0] rdata;
  int err_count = 0, compares = 0;
  tei_throttle_event_interrupt u_tei_throttle_event_interrupt(.ref_clk, .rst_b, .force_throttle_b,
    .low_side_timer_out(lo), .high_side_timer_out(hi), .reg_req(req), .reg_rdata(rdata), .throttle_irq);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic finish_test;
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(int n); repeat (n) @(posedge ref_clk); #1; endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic irq(logic e); chk("irq", {31'h0, e}, {31'h0, throttle_irq}); endtask
  // strobe is released at the edge that takes it
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [4:0] e);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk) req <= '0;
    #1 chk("rdata", {27'h0, e}, rdata);
  endtask
  task automatic t_reset;
    rd(TEI_STATUS_OFS, 5'h10);
    rd(TEI_ENABLE_OFS, 5'h00);
    rd(8'h24, 5'h00);
  endtask
  task automatic t_force;
    wr(TEI_STATUS_OFS, 32'h0);
    rd(TEI_STATUS_OFS, 5'h10);
    wr(TEI_STATUS_OFS, 32'h10);
    rd(TEI_STATUS_OFS, 5'h00);
    @(posedge ref_clk) force_throttle_b <= 1'b0;
    @(posedge ref_clk) force_throttle_b <= 1'b1;
    #1 irq(1'b0);
    rd(TEI_STATUS_OFS, 5'h10);
    wr(TEI_ENABLE_OFS, 32'h10);
    cyc(1);
    irq(1'b1);
    wr(TEI_STATUS_OFS, 32'h10);
    cyc(1);
    irq(1'b0);
  endtask
  task automatic t_edges;
    wr(TEI_ENABLE_OFS, 32'h0f);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) if (i % 2) hi <= (i < 2); else lo <= (i < 2);
      cyc(1);
      irq(1'b1);
      rd(TEI_STATUS_OFS, 5'h08 >> i);
      wr(TEI_STATUS_OFS, 32'h0f);
      cyc(1);
      irq(1'b0);
    end
  endtask
  task automatic t_collide;
    wr(TEI_ENABLE_OFS, 32'h10);
    @(posedge ref_clk) force_throttle_b <= 1'b0;
    cyc(1);
    irq(1'b1);
    wr(TEI_STATUS_OFS, 32'h10);
    rd(TEI_STATUS_OFS, 5'h10);
    irq(1'b1);
    @(posedge ref_clk) force_throttle_b <= 1'b1;
    wr(TEI_STATUS_OFS, 32'h10);
    cyc(1);
    irq(1'b0);
  endtask
  task automatic t_midreset;
    wr(TEI_ENABLE_OFS, 32'h1f);
    @(posedge ref_clk) force_throttle_b <= 1'b0;
    @(posedge ref_clk) force_throttle_b <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 irq(1'b0);
    rd(TEI_STATUS_OFS, 5'h10);
    rd(TEI_ENABLE_OFS, 5'h00);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_force();
    t_edges();
    t_collide();
    t_midreset();
    finish_test();
  end
  initial begin
    #10000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
